// file: src/acr_top.sv
`timescale 1ns/1ps
// Function
// - Live update bit 0 set allows biquad coefficient changes while running.
// - Primary override clear: primary port role follows primary role bit only.
// - Primary override set: role 0 bclk in/fsync out; role 1 opposite.
// - Secondary override clear: secondary port role follows secondary role bit only.
// - Secondary override set: same split as primary port.
// - Clock auto-detection is off for a port whose override is set.
// - Primary controller uses internal frame sync when bit 2 set and the primary port drives frame sync.
// - Secondary controller uses internal frame sync when bit 1 set and the secondary port drives frame sync.
// - Force-custom bit picks custom mask over standard channel limit selection.
// - Custom mask bits 6..3 enable channels 4..1.
// - Rate converter enable bit 7 turns converter on; resets to 0.
// - Rate auto-detection runs while bit 6 is zero.
module acr_top
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    input  wire logic       primary_role_sel,
    input  wire logic       secondary_role_sel,
    input  wire logic [3:0] standard_channel_limit_sel,
    output logic            filter_live_update_en,
    output logic            primary_bclk_out,
    output logic            primary_fsync_out,
    output logic            primary_autodetect_en,
    output logic            primary_use_internal_fsync,
    output logic            secondary_bclk_out,
    output logic            secondary_fsync_out,
    output logic            secondary_autodetect_en,
    output logic            secondary_use_internal_fsync,
    output logic      [3:0] channel_enable,
    output logic            rate_converter_on,
    output logic            rate_autodetect_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] page_sel_reg;
    logic [7:0] biquad_update_ctrl_reg;
    logic [7:0] serial_port_clock_role_ctrl_reg;
    logic [7:0] dynamic_channel_limit_ctrl_reg;
    logic [7:0] rate_converter_ctrl_a_reg;
    logic       primary_role_sync_reg;
    logic       primary_role_meta_reg;
    logic       secondary_role_sync_reg;
    logic       secondary_role_meta_reg;
    logic [3:0] std_limit_meta_reg;
    logic [3:0] std_limit_sync_reg;
    logic [3:0] std_limit_prev_reg;
    logic [3:0] std_limit_stable_reg;
    logic       bank_sel;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic in_bank);
        hit = in_bank && (a == target);
    endfunction

    assign bank_sel = (page_sel_reg == acr_pkg::BANK_PAGE);

    ////////////////////////////////////////////////////////////////////////////
    // Page select, reachable from every page

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            page_sel_reg <= acr_pkg::PAGE_SEL_RESET;
        else if (wr_en && addr == acr_pkg::PAGE_SEL_ADDR)
            page_sel_reg <= wr_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration writes; reserved positions are masked off

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            biquad_update_ctrl_reg <= acr_pkg::BIQUAD_UPDATE_RESET;
        else if (wr_en && hit(addr, acr_pkg::BIQUAD_UPDATE_ADDR, bank_sel))
            biquad_update_ctrl_reg <= wr_data & acr_pkg::BIQUAD_UPDATE_WMASK;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            serial_port_clock_role_ctrl_reg <= acr_pkg::CLOCK_ROLE_RESET;
        else if (wr_en && hit(addr, acr_pkg::CLOCK_ROLE_ADDR, bank_sel))
            serial_port_clock_role_ctrl_reg <= wr_data & acr_pkg::CLOCK_ROLE_WMASK;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            dynamic_channel_limit_ctrl_reg <= acr_pkg::CHANNEL_LIMIT_RESET;
        else if (wr_en && hit(addr, acr_pkg::CHANNEL_LIMIT_ADDR, bank_sel))
            dynamic_channel_limit_ctrl_reg <= wr_data & acr_pkg::CHANNEL_LIMIT_WMASK;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rate_converter_ctrl_a_reg <= acr_pkg::RATE_CONV_RESET;
        else if (wr_en && hit(addr, acr_pkg::RATE_CONV_ADDR, bank_sel))
            rate_converter_ctrl_a_reg <= wr_data & acr_pkg::RATE_CONV_WMASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: one cycle latency, unmapped or off-page reads give zero

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (!rd_en)
                rd_data <= 8'h00;
            else if (addr == acr_pkg::PAGE_SEL_ADDR)
                rd_data <= page_sel_reg;
            else if (hit(addr, acr_pkg::BIQUAD_UPDATE_ADDR, bank_sel))
                rd_data <= biquad_update_ctrl_reg;
            else if (hit(addr, acr_pkg::CLOCK_ROLE_ADDR, bank_sel))
                rd_data <= serial_port_clock_role_ctrl_reg;
            else if (hit(addr, acr_pkg::CHANNEL_LIMIT_ADDR, bank_sel))
                rd_data <= dynamic_channel_limit_ctrl_reg;
            else if (hit(addr, acr_pkg::RATE_CONV_ADDR, bank_sel))
                rd_data <= rate_converter_ctrl_a_reg;
            else
                rd_data <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Role and limit selectors arrive from outside this clock; two-stage sync

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            primary_role_meta_reg   <= 1'b0;
            primary_role_sync_reg   <= 1'b0;
            secondary_role_meta_reg <= 1'b0;
            secondary_role_sync_reg <= 1'b0;
        end
        else
        begin
            primary_role_meta_reg   <= primary_role_sel;
            primary_role_sync_reg   <= primary_role_meta_reg;
            secondary_role_meta_reg <= secondary_role_sel;
            secondary_role_sync_reg <= secondary_role_meta_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            std_limit_meta_reg <= 4'h0;
            std_limit_sync_reg <= 4'h0;
        end
        else
        begin
            std_limit_meta_reg <= standard_channel_limit_sel;
            std_limit_sync_reg <= std_limit_meta_reg;
        end
    end

    // Bits of the selector may resolve on different edges, so a mixed word
    // can leave the synchroniser; a value is only used once seen twice in a row
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            std_limit_prev_reg   <= 4'h0;
            std_limit_stable_reg <= 4'h0;
        end
        else
        begin
            std_limit_prev_reg <= std_limit_sync_reg;
            if (std_limit_sync_reg == std_limit_prev_reg)
                std_limit_stable_reg <= std_limit_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-port role decode

    acr_port_if prim_if ();
    acr_port_if sec_if ();

    assign prim_if.role_sel            = primary_role_sync_reg;
    assign prim_if.role_override       = serial_port_clock_role_ctrl_reg[acr_pkg::PRIMARY_OVERRIDE_BIT];
    assign prim_if.internal_frame_sync = serial_port_clock_role_ctrl_reg[acr_pkg::PRIMARY_INT_FS_BIT];
    assign sec_if.role_sel             = secondary_role_sync_reg;
    assign sec_if.role_override        = serial_port_clock_role_ctrl_reg[acr_pkg::SECONDARY_OVERRIDE_BIT];
    assign sec_if.internal_frame_sync  = serial_port_clock_role_ctrl_reg[acr_pkg::SECONDARY_INT_FS_BIT];

    acr_port_role u_primary
    (
        .p (prim_if.role)
    );

    acr_port_role u_secondary
    (
        .p (sec_if.role)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            primary_bclk_out             <= 1'b0;
            primary_fsync_out            <= 1'b0;
            primary_autodetect_en        <= 1'b1;
            primary_use_internal_fsync   <= 1'b0;
        end
        else
        begin
            primary_bclk_out             <= prim_if.bclk_out;
            primary_fsync_out            <= prim_if.fsync_out;
            primary_autodetect_en        <= prim_if.autodetect_en;
            primary_use_internal_fsync   <= prim_if.use_internal_fsync;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            secondary_bclk_out           <= 1'b0;
            secondary_fsync_out          <= 1'b0;
            secondary_autodetect_en      <= 1'b1;
            secondary_use_internal_fsync <= 1'b0;
        end
        else
        begin
            secondary_bclk_out           <= sec_if.bclk_out;
            secondary_fsync_out          <= sec_if.fsync_out;
            secondary_autodetect_en      <= sec_if.autodetect_en;
            secondary_use_internal_fsync <= sec_if.use_internal_fsync;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            channel_enable <= 4'h0;
        else if (dynamic_channel_limit_ctrl_reg[acr_pkg::FORCE_CUSTOM_BIT])
            channel_enable <= dynamic_channel_limit_ctrl_reg[acr_pkg::CUSTOM_MASK_LSB +: acr_pkg::CUSTOM_MASK_W];
        else
            channel_enable <= std_limit_stable_reg;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            filter_live_update_en <= 1'b0;
        else
            filter_live_update_en <= biquad_update_ctrl_reg[acr_pkg::LIVE_UPDATE_BIT];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_converter_on  <= 1'b0;
            rate_autodetect_en <= 1'b1;
        end
        else
        begin
            rate_converter_on  <= rate_converter_ctrl_a_reg[acr_pkg::RATE_ON_BIT];
            rate_autodetect_en <= ~rate_converter_ctrl_a_reg[acr_pkg::RATE_AUTODET_OFF_BIT];
        end
    end

endmodule

// file: src/acr_pkg.sv
package acr_pkg;

    // Register offsets within the selected page
    localparam logic [7:0] PAGE_SEL_ADDR        = 8'h00;
    localparam logic [7:0] BIQUAD_UPDATE_ADDR   = 8'h03;
    localparam logic [7:0] CLOCK_ROLE_ADDR      = 8'h0D;
    localparam logic [7:0] CHANNEL_LIMIT_ADDR   = 8'h0E;
    localparam logic [7:0] RATE_CONV_ADDR       = 8'h17;

    // Page that holds this bank
    localparam logic [7:0] BANK_PAGE            = 8'h00;

    // Reset values
    localparam logic [7:0] PAGE_SEL_RESET       = 8'h00;
    localparam logic [7:0] BIQUAD_UPDATE_RESET  = 8'h00;
    localparam logic [7:0] CLOCK_ROLE_RESET     = 8'h00;
    localparam logic [7:0] CHANNEL_LIMIT_RESET  = 8'h00;
    localparam logic [7:0] RATE_CONV_RESET      = 8'h00;

    // Writable bit masks; all other positions are reserved and read as zero
    localparam logic [7:0] BIQUAD_UPDATE_WMASK  = 8'h01;
    localparam logic [7:0] CLOCK_ROLE_WMASK     = 8'hC6;
    localparam logic [7:0] CHANNEL_LIMIT_WMASK  = 8'hF8;
    localparam logic [7:0] RATE_CONV_WMASK      = 8'hC0;

    // Field positions
    localparam int LIVE_UPDATE_BIT        = 0;
    localparam int PRIMARY_OVERRIDE_BIT   = 7;
    localparam int SECONDARY_OVERRIDE_BIT = 6;
    localparam int PRIMARY_INT_FS_BIT     = 2;
    localparam int SECONDARY_INT_FS_BIT   = 1;
    localparam int FORCE_CUSTOM_BIT       = 7;
    localparam int CUSTOM_MASK_LSB        = 3;
    localparam int CUSTOM_MASK_W          = 4;
    localparam int RATE_ON_BIT            = 7;
    localparam int RATE_AUTODET_OFF_BIT   = 6;

endpackage

// file: src/acr_port_if.sv
`timescale 1ns/1ps
interface acr_port_if;
    logic role_sel;
    logic role_override;
    logic internal_frame_sync;
    logic bclk_out;
    logic fsync_out;
    logic autodetect_en;
    logic use_internal_fsync;

    modport ctrl
    (
        output role_sel,
        output role_override,
        output internal_frame_sync,
        input  bclk_out,
        input  fsync_out,
        input  autodetect_en,
        input  use_internal_fsync
    );
    modport role
    (
        input  role_sel,
        input  role_override,
        input  internal_frame_sync,
        output bclk_out,
        output fsync_out,
        output autodetect_en,
        output use_internal_fsync
    );
endinterface

// file: src/acr_port_role.sv
`timescale 1ns/1ps
// Combinational role decode for one serial port
module acr_port_role
(
    acr_port_if.role p
);
    always_comb
    begin
        if (p.role_override)
        begin
            // Split roles: selector 1 drives bit clock, receives frame sync
            p.bclk_out  = p.role_sel;
            p.fsync_out = ~p.role_sel;
        end
        else
        begin
            p.bclk_out  = p.role_sel;
            p.fsync_out = p.role_sel;
        end
        p.autodetect_en      = ~p.role_override;
        // Internal frame sync only meaningful when this end drives frame sync
        p.use_internal_fsync = p.fsync_out & p.internal_frame_sync;
    end
endmodule

// file: sim/acr_checker.sv
`timescale 1ns/1ps
module acr_checker
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic       primary_role_sel,
    input wire logic       filter_live_update_en,
    input wire logic       primary_bclk_out,
    input wire logic       primary_fsync_out,
    input wire logic       primary_autodetect_en,
    input wire logic       primary_use_internal_fsync,
    input wire logic       secondary_bclk_out,
    input wire logic       secondary_fsync_out,
    input wire logic       secondary_autodetect_en,
    input wire logic [3:0] channel_enable,
    input wire logic       rate_converter_on,
    input wire logic       rate_autodetect_en
);
    // Shadow of the page so writes to other pages are not expected to land
    logic [7:0] page_reg;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            page_reg <= 8'h00;
        else if (wr_en && addr == acr_pkg::PAGE_SEL_ADDR)
            page_reg <= wr_data;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr(a);
        wr_en && addr == a && page_reg == acr_pkg::BANK_PAGE;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_read_valid_pulse: assert property (rd_en |=> rd_valid)
        else $error("read not answered one cycle later");
    a_no_idle_valid: assert property (!rd_en |=> !rd_valid)
        else $error("read valid without a read");
    a_unmapped_read_zero: assert property (rd_en && !(addr inside {8'h00, 8'h03, 8'h0D, 8'h0E, 8'h17})
        |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_role_tracks_input: assert property ($stable(primary_role_sel) [*5] |-> primary_bclk_out == primary_role_sel)
        else $error("primary bit clock direction does not follow role");
    a_fsync_role_split: assert property (
        primary_fsync_out == (primary_bclk_out ^ !primary_autodetect_en)
        && secondary_fsync_out == (secondary_bclk_out ^ !secondary_autodetect_en))
        else $error("frame sync direction inconsistent with override");
    a_int_fsync_gated: assert property (primary_use_internal_fsync |-> primary_fsync_out)
        else $error("internal frame sync without driving frame sync");
    a_live_update_write: assert property (s_wr(acr_pkg::BIQUAD_UPDATE_ADDR)
        |-> ##2 filter_live_update_en == $past(wr_data[0], 2))
        else $error("live update enable not taken from write");
    a_custom_mask_write: assert property (s_wr(acr_pkg::CHANNEL_LIMIT_ADDR) ##0 wr_data[7]
        |-> ##2 channel_enable == $past(wr_data[6:3], 2))
        else $error("custom channel mask not applied");
    a_rate_ctrl_write: assert property (s_wr(acr_pkg::RATE_CONV_ADDR) |-> ##2
        (rate_converter_on == $past(wr_data[7], 2) && rate_autodetect_en == !$past(wr_data[6], 2)))
        else $error("rate converter controls not taken from write");
endmodule
bind acr_top acr_checker u_acr_checker (.*);

// file: sim/acr_top_tb_top.sv
`timescale 1ns/1ps
module acr_top_tb_top;
    logic       ref_clk, rst_n, wr_en, rd_en, rd_valid, primary_role_sel, secondary_role_sel;
    logic [7:0] addr, wr_data, rd_data, d;
    logic [3:0] standard_channel_limit_sel, channel_enable;
    logic       filter_live_update_en, rate_converter_on, rate_autodetect_en;
    logic       primary_bclk_out, primary_fsync_out, primary_autodetect_en, primary_use_internal_fsync;
    logic       secondary_bclk_out, secondary_fsync_out, secondary_autodetect_en, secondary_use_internal_fsync;
    int         miscompares, checked, seed;
    logic [7:0] expect_q[$];
    logic [7:0] regs[5]  = '{8'h00, 8'h03, 8'h0D, 8'h0E, 8'h17};
    logic [7:0] masks[5] = '{8'hFF, 8'h01, 8'hC6, 8'hF8, 8'hC0};

    acr_top DUT (.*);

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        #1;
        {wr_en, addr, wr_data} = {1'b1, a, v};
        @(posedge ref_clk);
        #1;
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        expect_q.push_back(exp);
        @(posedge ref_clk);
        #1;
        {rd_en, addr} = {1'b1, a};
        @(posedge ref_clk);
        #1;
        rd_en = 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Expected {bclk out, fsync out, autodetect, internal fsync} of one port
    function automatic logic [7:0] port_exp(input logic ovr, input logic r, input logic fs);
        return {4'h0, r, ovr ? !r : r, !ovr, (ovr ? !r : r) & fs};
    endfunction
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Mid-cycle look: the one-cycle read pulse is settled, away from its launch edge
    always @(negedge ref_clk)
    begin
        if (rd_valid === 1'b1)
        begin
            if (expect_q.size() == 0)
                check("unexpected_read", 8'h01, 8'h00);
            else
                check("rd_data", rd_data, expect_q.pop_front());
        end
    end

    initial
    begin
        #100us;
        miscompares++;
        conclude();
    end

    initial
    begin
        seed = 53553;
        {rst_n, wr_en, rd_en, addr, wr_data, primary_role_sel, secondary_role_sel} = '0;
        standard_channel_limit_sel = 4'h0;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        check("rate_autodetect_en", {7'h00, rate_autodetect_en}, 8'h01);
        wr(8'h00, 8'h00);
        for (int i = 0; i < 5; i++)
            rd(regs[i], 8'h00);
        // Page register skipped here: all ones would move the bank off page
        for (int i = 1; i < 5; i++)
        begin
            wr(regs[i], masks[i]);
            rd(regs[i], masks[i]);
        end
        rd(8'h04, 8'h00);
        rd(8'hFF, 8'h00);
        check("live_update", {7'h00, filter_live_update_en}, 8'h01);
        wr(8'h03, 8'h00);
        settle(2);
        check("live_update", {7'h00, filter_live_update_en}, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h0D, {i[2], i[2], 3'b000, i[0], i[0], 1'b0});
            primary_role_sel = i[1];
            secondary_role_sel = !i[1];
            settle(5);
            check("primary_port", {4'h0, primary_bclk_out, primary_fsync_out, primary_autodetect_en,
                primary_use_internal_fsync}, port_exp(i[2], i[1], i[0]));
            check("secondary_port", {4'h0, secondary_bclk_out, secondary_fsync_out, secondary_autodetect_en,
                secondary_use_internal_fsync}, port_exp(i[2], !i[1], i[0]));
        end
        for (int i = 0; i < 8; i++)
        begin
            d = {i[0], 4'($random(seed)), 3'b000};
            standard_channel_limit_sel = 4'($random(seed));
            wr(8'h0E, d);
            settle(4);
            check("channel_enable", {4'h0, channel_enable}, {4'h0, d[7] ? d[6:3] : standard_channel_limit_sel});
            rd(8'h0E, d & 8'hF8);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h17, {i[1:0], 6'h00});
            settle(2);
            check("rate_ctrl", {6'h00, rate_converter_on, rate_autodetect_en}, {6'h00, i[1], !i[0]});
            rd(8'h17, {i[1:0], 6'h00});
        end
        wr(8'h00, 8'h01);
        wr(8'h17, 8'h00);
        rd(8'h17, 8'h00);
        rd(8'h00, 8'h01);
        settle(2);
        check("rate_off_page", {7'h00, rate_converter_on}, 8'h01);
        wr(8'h00, 8'h00);
        rd(8'h17, 8'hC0);
        settle(3);
        check("pending_reads", 8'(expect_q.size()), 8'h00);
        conclude();
    end
endmodule
